// ---- include/fdss_defines.svh ----
`ifndef FDSS_DEFINES_SVH
`define FDSS_DEFINES_SVH
`define FDSS_CTRL_WIDTH 16
`define FDSS_RSVD_MSB 15
`define FDSS_RSVD_LSB 10
`define FDSS_RSVD_RESET 6'h00
`define FDSS_BIT_CUR_B_UNDER 9
`define FDSS_BIT_CUR_B_OVER 8
`define FDSS_BIT_CUR_A_UNDER 7
`define FDSS_BIT_CUR_A_OVER 6
`define FDSS_BIT_U_UNDER 5
`define FDSS_BIT_U_OVER 4
`define FDSS_SEL_LSB 4
`define FDSS_SEL_COUNT 6
`define FDSS_SEL_RESET 6'h00
`endif

// ---- include/fdss_pkg.sv ----
package fdss_pkg;
  typedef logic [5:0] fdss_sel_t;
  typedef enum logic {
    FDSS_SRC_RAW = 1'b0,
    FDSS_SRC_HPF = 1'b1
  } fdss_src_e;
endpackage

// ---- rtl/fdss_src_mux.sv ----
`timescale 1ns/1ps
module fdss_src_mux
  import fdss_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input wire logic sel,
  input wire logic [DATA_W-1:0] raw_wave,
  input wire logic [DATA_W-1:0] hpf_wave,
  output logic [DATA_W-1:0] det_wave
);
  wire logic use_hpf;
  assign use_hpf = (sel == FDSS_SRC_HPF);
  // Unfiltered waveform whenever the select bit is clear
  assign det_wave = use_hpf ? hpf_wave : raw_wave;
endmodule

// ---- rtl/fdss_select.sv ----
// Overview of operation
// - Bit 9 routes filtered wave to B under-current.
// - Bit 8 routes filtered wave to B over-current.
// - Bit 7 routes filtered wave to A under-current.
// - Bit 6 routes filtered wave to A over-current.
// - Bit 5 routes filtered wave to under-voltage.
// - Bit 4 routes filtered wave to over-voltage.
`timescale 1ns/1ps
`include "fdss_defines.svh"
module fdss_select
  import fdss_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] ctrl_rdata,
  input wire logic [DATA_W-1:0] current_channel_a_raw,
  input wire logic [DATA_W-1:0] current_channel_a_hpf,
  input wire logic [DATA_W-1:0] current_channel_b_raw,
  input wire logic [DATA_W-1:0] current_channel_b_hpf,
  input wire logic [DATA_W-1:0] voltage_raw,
  input wire logic [DATA_W-1:0] voltage_hpf,
  output logic current_b_under_src_sel,
  output logic current_b_over_src_sel,
  output logic current_a_under_src_sel,
  output logic current_a_over_src_sel,
  output logic voltage_under_src_sel,
  output logic voltage_over_src_sel,
  output logic [DATA_W-1:0] current_b_under_wave,
  output logic [DATA_W-1:0] current_b_over_wave,
  output logic [DATA_W-1:0] current_a_under_wave,
  output logic [DATA_W-1:0] current_a_over_wave,
  output logic [DATA_W-1:0] voltage_under_wave,
  output logic [DATA_W-1:0] voltage_over_wave
);
  fdss_sel_t sel_r;
  fdss_sel_t sel_nxt;
  logic [5:0] rsvd_r;
  logic [5:0] rsvd_nxt;
  wire logic [DATA_W-1:0] raw_vec [6];
  wire logic [DATA_W-1:0] hpf_vec [6];
  wire logic [DATA_W-1:0] wave_vec [6];

  // Reserved bits are stored as written so software can read back what it wrote
  assign sel_nxt = ctrl_wr ? ctrl_wdata[`FDSS_BIT_CUR_B_UNDER:`FDSS_SEL_LSB] : sel_r;
  assign rsvd_nxt = ctrl_wr ? ctrl_wdata[`FDSS_RSVD_MSB:`FDSS_RSVD_LSB] : rsvd_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_r <= `FDSS_SEL_RESET;
      rsvd_r <= `FDSS_RSVD_RESET;
    end else begin
      sel_r <= sel_nxt;
      rsvd_r <= rsvd_nxt;
    end
  end

  // One decode for all six selects keeps the bit map in a single place
  function automatic logic pick_sel(input fdss_sel_t sel, input int pos);
    return sel[pos-`FDSS_SEL_LSB];
  endfunction

  assign ctrl_rdata = {rsvd_r, sel_r, 4'h0};
  assign current_b_under_src_sel = pick_sel(sel_r, `FDSS_BIT_CUR_B_UNDER);
  assign current_b_over_src_sel = pick_sel(sel_r, `FDSS_BIT_CUR_B_OVER);
  assign current_a_under_src_sel = pick_sel(sel_r, `FDSS_BIT_CUR_A_UNDER);
  assign current_a_over_src_sel = pick_sel(sel_r, `FDSS_BIT_CUR_A_OVER);
  assign voltage_under_src_sel = pick_sel(sel_r, `FDSS_BIT_U_UNDER);
  assign voltage_over_src_sel = pick_sel(sel_r, `FDSS_BIT_U_OVER);

  // Index i matches select bit i+4
  assign raw_vec[0] = voltage_raw;
  assign raw_vec[1] = voltage_raw;
  assign raw_vec[2] = current_channel_a_raw;
  assign raw_vec[3] = current_channel_a_raw;
  assign raw_vec[4] = current_channel_b_raw;
  assign raw_vec[5] = current_channel_b_raw;
  assign hpf_vec[0] = voltage_hpf;
  assign hpf_vec[1] = voltage_hpf;
  assign hpf_vec[2] = current_channel_a_hpf;
  assign hpf_vec[3] = current_channel_a_hpf;
  assign hpf_vec[4] = current_channel_b_hpf;
  assign hpf_vec[5] = current_channel_b_hpf;

  for (genvar i = 0; i < `FDSS_SEL_COUNT; i++) begin : g_mux
    fdss_src_mux #(.DATA_W(DATA_W)) u_mux (
      .sel(sel_r[i]),
      .raw_wave(raw_vec[i]),
      .hpf_wave(hpf_vec[i]),
      .det_wave(wave_vec[i])
    );
  end

  // Waves are combinational through the mux; detectors register them anyway
  assign voltage_over_wave = wave_vec[0];
  assign voltage_under_wave = wave_vec[1];
  assign current_a_over_wave = wave_vec[2];
  assign current_a_under_wave = wave_vec[3];
  assign current_b_over_wave = wave_vec[4];
  assign current_b_under_wave = wave_vec[5];

  property p_write_takes;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> (ctrl_rdata[9:4] == $past(ctrl_wdata[9:4]));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("select not loaded");

  property p_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !ctrl_wr |=> $stable(ctrl_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_reset_zero;
    @(posedge ref_clk) sys_rst |=> (ctrl_rdata == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_b_under;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> current_b_under_src_sel == $past(ctrl_wdata[9]);
  endproperty
  a_b_under: assert property (p_b_under) else $error("bit 9 select wrong");

  property p_b_over;
    @(posedge ref_clk) disable iff (sys_rst)
      current_b_over_wave == (current_b_over_src_sel ? current_channel_b_hpf
                                                     : current_channel_b_raw);
  endproperty
  a_b_over: assert property (p_b_over) else $error("B over source wrong");

  property p_a_under;
    @(posedge ref_clk) disable iff (sys_rst)
      current_a_under_wave == (ctrl_rdata[7] ? current_channel_a_hpf : current_channel_a_raw);
  endproperty
  a_a_under: assert property (p_a_under) else $error("A under source wrong");

  property p_a_over;
    @(posedge ref_clk) disable iff (sys_rst)
      current_a_over_wave == (ctrl_rdata[6] ? current_channel_a_hpf : current_channel_a_raw);
  endproperty
  a_a_over: assert property (p_a_over) else $error("A over source wrong");

  property p_u_under;
    @(posedge ref_clk) disable iff (sys_rst)
      voltage_under_wave == (ctrl_rdata[5] ? voltage_hpf : voltage_raw);
  endproperty
  a_u_under: assert property (p_u_under) else $error("U under source wrong");

  property p_u_over;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr ##1 !ctrl_wr |-> voltage_over_src_sel == $past(ctrl_wdata[4]);
  endproperty
  a_u_over: assert property (p_u_over) else $error("bit 4 select wrong");

  property p_b_under_wave;
    @(posedge ref_clk) disable iff (sys_rst)
      current_b_under_wave == (ctrl_rdata[9] ? current_channel_b_hpf : current_channel_b_raw);
  endproperty
  a_b_under_wave: assert property (p_b_under_wave) else $error("B under source wrong");

  property p_u_over_wave;
    @(posedge ref_clk) disable iff (sys_rst)
      voltage_over_wave == (voltage_over_src_sel ? voltage_hpf : voltage_raw);
  endproperty
  a_u_over_wave: assert property (p_u_over_wave) else $error("U over source wrong");

  property p_b_over_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> current_b_over_src_sel == $past(ctrl_wdata[8]);
  endproperty
  a_b_over_sel: assert property (p_b_over_sel) else $error("bit 8 select wrong");

  property p_a_under_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> current_a_under_src_sel == $past(ctrl_wdata[7]);
  endproperty
  a_a_under_sel: assert property (p_a_under_sel) else $error("bit 7 select wrong");

  property p_a_over_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> current_a_over_src_sel == $past(ctrl_wdata[6]);
  endproperty
  a_a_over_sel: assert property (p_a_over_sel) else $error("bit 6 select wrong");

  property p_u_under_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> voltage_under_src_sel == $past(ctrl_wdata[5]);
  endproperty
  a_u_under_sel: assert property (p_u_under_sel) else $error("bit 5 select wrong");

  // Reserved bits are stored only; what they would do in the device is undefined
  property p_rsvd_store;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> ctrl_rdata[15:10] == $past(ctrl_wdata[15:10]);
  endproperty
  a_rsvd_store: assert property (p_rsvd_store) else $error("reserved bits not stored");

  property p_reset_sel;
    @(posedge ref_clk) sys_rst |=> !(current_b_under_src_sel || current_b_over_src_sel
      || current_a_under_src_sel || current_a_over_src_sel || voltage_under_src_sel
      || voltage_over_src_sel);
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("select set after reset");

  // After reset the over-voltage, B under-current and A over-current detectors must see the unfiltered waveform
  property p_reset_raw;
    @(posedge ref_clk) sys_rst |=>
      (voltage_over_wave == voltage_raw) && (current_b_under_wave == current_channel_b_raw)
      && (current_a_over_wave == current_channel_a_raw);
  endproperty
  a_reset_raw: assert property (p_reset_raw) else $error("reset did not select raw");

  property p_sel_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !ctrl_wr |=> $stable(voltage_over_src_sel) && $stable(current_b_under_src_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved without write");

  c_all_hpf: cover property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_wr && ctrl_wdata[9:4] == 6'h3F ##1 ctrl_rdata[9:4] == 6'h3F);
  c_back_raw: cover property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_rdata[9:4] == 6'h3F ##[1:20] ctrl_rdata[9:4] == 6'h00);
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_wr ##1 ctrl_wr);
  c_mid_reset: cover property (@(posedge ref_clk)
    (ctrl_rdata != 16'h0000) && sys_rst ##1 !sys_rst);
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ctrl_wr = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000;
  logic [15:0] nxt = 16'h0000;
  logic [15:0] e;
  logic [23:0] wv [6];
  wire [15:0] rd;
  wire [5:0] sel;
  wire [23:0] ow [6];
  logic [15:0] q [$];
  integer seed = 32'hBDFD;
  integer failures = 0;
  integer checks_done = 0;
  integer k;

  fdss_select #(.DATA_W(24)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(rd),
    .current_channel_a_raw(wv[0]), .current_channel_a_hpf(wv[1]),
    .current_channel_b_raw(wv[2]), .current_channel_b_hpf(wv[3]),
    .voltage_raw(wv[4]), .voltage_hpf(wv[5]),
    .current_b_under_src_sel(sel[5]), .current_b_over_src_sel(sel[4]),
    .current_a_under_src_sel(sel[3]), .current_a_over_src_sel(sel[2]),
    .voltage_under_src_sel(sel[1]), .voltage_over_src_sel(sel[0]),
    .current_b_under_wave(ow[5]), .current_b_over_wave(ow[4]),
    .current_a_under_wave(ow[3]), .current_a_over_wave(ow[2]),
    .voltage_under_wave(ow[1]), .voltage_over_wave(ow[0])
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Each note records the state the previous edge's drive should produce
  task step(input logic r, input logic w, input logic [15:0] d);
    integer i;
    @(posedge ref_clk);
    q.push_back(nxt);
    sys_rst <= r;
    ctrl_wr <= w;
    ctrl_wdata <= d;
    for (i = 0; i < 6; i++)
      wv[i] <= 24'($random(seed));
    nxt = r ? 16'h0000 : (w ? (d & 16'hFFF0) : nxt);
  endtask

  // Waves are combinational, so they are judged against the inputs of this cycle
  always @(negedge ref_clk) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      chk({8'h00, rd}, {8'h00, e});
      for (k = 0; k < 6; k++) begin
        chk({23'h0, sel[k]}, {23'h0, e[k+4]});
        chk(ow[k], wv[(k >= 4 ? 2 : (k >= 2 ? 0 : 4)) + int'(e[k+4])]);
      end
    end
  end

  initial begin
    for (int j = 0; j < 6; j++)
      wv[j] = 24'h000000;
    repeat (16) step(1'b1, 1'b1, 16'h03F0);
    for (int b = 4; b < 10; b++) begin
      step(1'b0, 1'b1, 16'h0001 << b);
      step(1'b0, 1'b0, 16'h0000);
    end
    step(1'b0, 1'b1, 16'h000F);
    step(1'b0, 1'b1, 16'h0350);
    step(1'b0, 1'b1, 16'h02A0);
    step(1'b0, 1'b1, 16'h0000);
    repeat (40) step(1'b0, 1'($random(seed)), 16'($random(seed)) & 16'h03FF);
    step(1'b0, 1'b1, 16'h03F0);
    step(1'b1, 1'b1, 16'h03F0);
    step(1'b0, 1'b0, 16'h0000);
    step(1'b0, 1'b0, 16'h0000);
    // Second negedge lets the checker take the last note before the run ends
    repeat (2) @(negedge ref_clk);
    close_out;
  end

  // Whole run is about 78 cycles; this bound leaves a wide margin
  initial begin
    repeat (1000) @(posedge ref_clk);
    failures++;
    close_out;
  end
endmodule
